// >>> core/ufm_consts.vh
// Purpose: constants for the channel mode, fifo threshold and watchdog block
// Assumes: 4-bit register address, 8-bit data
// Notes: definitions only
`ifndef UFM_CONSTS_VH
`define UFM_CONSTS_VH

// register offsets
`define UFM_OFS_MODE 4'h0
`define UFM_OFS_CMD 4'h1
`define UFM_OFS_STATUS 4'h2
`define UFM_OFS_IRQ_STAT 4'h3
`define UFM_OFS_IRQ_MASK 4'h4

// reset values
`define UFM_RST_MODE0 8'h00
`define UFM_RST_MODE1 8'h00
`define UFM_RST_MODE2 8'h00
`define UFM_RST_MASK 8'h00

// fifo_irq_baud_mode fields
`define UFM_M0_IDLE_EN 7
`define UFM_M0_RX_THR_HI 6
`define UFM_M0_TX_THR_HI 5
`define UFM_M0_TX_THR_LO 4
`define UFM_M0_DEPTH 3
`define UFM_M0_RATE_HI 2
`define UFM_M0_RATE_LO 0
// char_format_mode field
`define UFM_M1_RX_THR_LO 6

// mode pointer values
`define UFM_PTR_M0 2'h0
`define UFM_PTR_M1 2'h1
`define UFM_PTR_M2 2'h2

// channel command codes (bits 7:4 of the command register)
`define UFM_CMD_MSB 7
`define UFM_CMD_LSB 4
`define UFM_CMD_PTR_M1 4'h1
`define UFM_CMD_PTR_M0 4'hb

// rate group codes
`define UFM_RATE_NORMAL 3'h0
`define UFM_RATE_EXT_A 3'h1
`define UFM_RATE_EXT_B 3'h4

// fifo depths and threshold levels
`define UFM_DEPTH_SMALL 5'h08
`define UFM_DEPTH_LARGE 5'h10
`define UFM_RX_S1 5'h03
`define UFM_RX_S2 5'h06
`define UFM_RX_L1 5'h08
`define UFM_RX_L2 5'h0c
`define UFM_TX_S1 5'h04
`define UFM_TX_S2 5'h06
`define UFM_TX_L1 5'h08
`define UFM_TX_L2 5'h0c

// receive idle watchdog, counted in receiver 1x bit periods
`define UFM_IDLE_BITS 7'h40

// status register bit positions
`define UFM_ST_RX_HAS_CHAR 0
`define UFM_ST_RX_FULL 1
`define UFM_ST_TX_SPACE 2
`define UFM_ST_TX_DRAINED 3
`define UFM_ST_IDLE_FIRED 4

// interrupt status bit positions
`define UFM_IS_TX 0
`define UFM_IS_RX 1
`define UFM_IS_IDLE 2

`endif

// >>> core/ufm_mode_ctl.v
// Purpose: mode register pointer, fifo interrupt thresholds, depth and rate
//          group selection and the receive idle watchdog of one channel
// Assumes: fifo counts and access strobes come from the fifo logic, all
//          synchronous to CLOCK_IN; RX_BIT_TICK_IN pulses once per 1x bit time
// Notes: register read data appear in the cycle after the read strobe only
//        watchdog only runs while the receive fifo holds data
//        thresholds and depth switch over at a safe moment only
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "ufm_consts.vh"

module ufm_mode_ctl (
    input wire CLOCK_IN,              // 10 MHz system clock
    input wire RST_IN,                // asynchronous reset, active high
    input wire [3:0] ADDR_IN,         // register address
    input wire [7:0] WDATA_IN,        // register write data
    input wire WR_IN,                 // register write strobe
    input wire RD_IN,                 // register read strobe
    output reg [7:0] RDATA_OUT,       // read data, cycle after read strobe
    input wire [4:0] RX_COUNT_IN,     // bytes held in receive fifo
    input wire [4:0] TX_COUNT_IN,     // bytes held in transmit fifo
    input wire RX_FIFO_RD_IN,         // receive fifo read strobe
    input wire RX_FIFO_WR_IN,         // receive fifo write strobe
    input wire TX_FIFO_RD_IN,         // transmit fifo read strobe
    input wire TX_FIFO_WR_IN,         // transmit fifo write strobe
    input wire RX_BIT_TICK_IN,        // one pulse per receiver 1x bit period
    input wire TX_ENABLE_IN,          // transmitter enabled
    output reg RX_IRQ_LEVEL_OUT,      // receiver interrupt request
    output reg TX_IRQ_LEVEL_OUT,      // transmitter interrupt request
    output reg QUEUE_DEPTH_SEL_OUT,   // 0: 8-byte fifos, 1: 16-byte fifos
    output reg [2:0] RATE_GROUP_OUT,  // baud rate group code
    output reg [7:0] CHAR_FORMAT_OUT, // char_format_mode contents
    output reg [7:0] LINE_MODE_OUT,   // line_mode_reg contents
    output reg IRQ_OUT                // masked interrupt, level
);

    // ==========================================================
    // storage
    reg [7:0] fifo_irq_baud_mode_ff;
    reg [7:0] char_format_mode_ff;
    reg [7:0] line_mode_reg_ff;
    reg [1:0] mode_ptr_ff;
    reg [1:0] act_rx_thr_ff;
    reg [1:0] act_tx_thr_ff;
    reg act_depth_ff;
    reg [6:0] idle_cnt_ff;
    reg idle_fired_ff;
    reg [2:0] irq_stat_ff;
    reg [2:0] irq_mask_ff;
    reg rx_req_d_ff;
    reg tx_req_d_ff;

    reg [1:0] nxt_mode_ptr;
    reg [4:0] rx_level;
    reg [4:0] tx_level;
    reg [4:0] depth;
    reg [4:0] tx_empty;
    reg rx_met;
    reg tx_met;
    reg [7:0] nxt_rdata;
    reg [7:0] status_word;
    reg [7:0] mode_word;
    genvar g;

    wire mode_wr = WR_IN && (ADDR_IN == `UFM_OFS_MODE);
    wire mode_rd = RD_IN && (ADDR_IN == `UFM_OFS_MODE);
    wire cmd_wr = WR_IN && (ADDR_IN == `UFM_OFS_CMD);
    wire [3:0] cmd_code = WDATA_IN[`UFM_CMD_MSB:`UFM_CMD_LSB];
    wire ptr_to_m1 = cmd_wr && (cmd_code == `UFM_CMD_PTR_M1);
    wire ptr_to_m0 = cmd_wr && (cmd_code == `UFM_CMD_PTR_M0);
    wire stat_wr = WR_IN && (ADDR_IN == `UFM_OFS_IRQ_STAT);
    wire fifo_access = RX_FIFO_RD_IN | RX_FIFO_WR_IN | TX_FIFO_RD_IN | TX_FIFO_WR_IN;
    wire rx_access = RX_FIFO_RD_IN | RX_FIFO_WR_IN;
    wire fifos_empty = (RX_COUNT_IN == 5'h00) && (TX_COUNT_IN == 5'h00);
    wire shadow_load = fifos_empty || fifo_access;
    wire idle_en = fifo_irq_baud_mode_ff[`UFM_M0_IDLE_EN];
    wire [1:0] rx_thr_code = {fifo_irq_baud_mode_ff[`UFM_M0_RX_THR_HI],
                              char_format_mode_ff[`UFM_M1_RX_THR_LO]};
    wire [1:0] tx_thr_code = fifo_irq_baud_mode_ff[`UFM_M0_TX_THR_HI:`UFM_M0_TX_THR_LO];
    wire rx_req = rx_met | idle_fired_ff;
    wire tx_req = tx_met & TX_ENABLE_IN;
    wire idle_hit = RX_BIT_TICK_IN && (idle_cnt_ff == `UFM_IDLE_BITS - 7'h01);
    wire idle_set = idle_en && !rx_access && !idle_fired_ff && idle_hit
                    && (RX_COUNT_IN != 5'h00);
    wire [2:0] irq_event = {idle_set,
                            rx_req & ~rx_req_d_ff,
                            tx_req & ~tx_req_d_ff};
    wire irq_any = |(irq_stat_ff & irq_mask_ff);

    // ==========================================================
    // mode pointer sequencing
    always @* begin
        nxt_mode_ptr = mode_ptr_ff;
        if (ptr_to_m1) begin
            nxt_mode_ptr = `UFM_PTR_M1;
        end else if (ptr_to_m0) begin
            nxt_mode_ptr = `UFM_PTR_M0;
        end else if (mode_wr || mode_rd) begin
            case (mode_ptr_ff)
                `UFM_PTR_M0: nxt_mode_ptr = `UFM_PTR_M1;
                `UFM_PTR_M1: nxt_mode_ptr = `UFM_PTR_M2;
                // mode two is the end of the chain
                default: nxt_mode_ptr = `UFM_PTR_M2;
            endcase
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mode_ptr_ff <= `UFM_PTR_M1;
        end else begin
            mode_ptr_ff <= nxt_mode_ptr;
        end
    end

    // ==========================================================
    // mode register storage, one address shared through the pointer
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fifo_irq_baud_mode_ff <= `UFM_RST_MODE0;
            char_format_mode_ff <= `UFM_RST_MODE1;
            line_mode_reg_ff <= `UFM_RST_MODE2;
        end else if (mode_wr) begin
            case (mode_ptr_ff)
                `UFM_PTR_M0: fifo_irq_baud_mode_ff <= WDATA_IN;
                `UFM_PTR_M1: char_format_mode_ff <= WDATA_IN;
                default: line_mode_reg_ff <= WDATA_IN;
            endcase
        end
    end

    // ==========================================================
    // thresholds take effect only at a safe moment
    // a swap mid-fill would move the request without any fifo event
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            act_rx_thr_ff <= 2'h0;
        end else if (shadow_load) begin
            act_rx_thr_ff <= rx_thr_code;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            act_tx_thr_ff <= 2'h0;
        end else if (shadow_load) begin
            act_tx_thr_ff <= tx_thr_code;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            act_depth_ff <= 1'b0;
        end else if (shadow_load) begin
            act_depth_ff <= fifo_irq_baud_mode_ff[`UFM_M0_DEPTH];
        end
    end

    // ==========================================================
    // fill level compare
    always @* begin
        depth = act_depth_ff ? `UFM_DEPTH_LARGE : `UFM_DEPTH_SMALL;
        tx_empty = depth - TX_COUNT_IN;
    end

    // ==========================================================
    // receive level per threshold code
    always @* begin
        case (act_rx_thr_ff)
            2'h0: rx_level = 5'h01;
            2'h1: rx_level = act_depth_ff ? `UFM_RX_L1 : `UFM_RX_S1;
            2'h2: rx_level = act_depth_ff ? `UFM_RX_L2 : `UFM_RX_S2;
            default: rx_level = depth;
        endcase
        rx_met = (RX_COUNT_IN >= rx_level);
    end

    // ==========================================================
    // transmit empty positions per threshold code
    always @* begin
        case (act_tx_thr_ff)
            2'h0: tx_level = depth;
            2'h1: tx_level = act_depth_ff ? `UFM_TX_L1 : `UFM_TX_S1;
            2'h2: tx_level = act_depth_ff ? `UFM_TX_L2 : `UFM_TX_S2;
            default: tx_level = 5'h01;
        endcase
        tx_met = (TX_COUNT_IN <= depth) && (tx_empty >= tx_level);
    end

    // ==========================================================
    // receive idle watchdog
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            idle_cnt_ff <= 7'h00;
        end else if (!idle_en || rx_access) begin
            idle_cnt_ff <= 7'h00;
        end else if (RX_COUNT_IN == 5'h00) begin
            idle_cnt_ff <= 7'h00;
        end else if (idle_hit) begin
            idle_cnt_ff <= 7'h00;
        end else if (RX_BIT_TICK_IN) begin
            idle_cnt_ff <= idle_cnt_ff + 7'h01;
        end
    end

    // ==========================================================
    // expiry flag, held until the receive fifo is touched or the watchdog is disabled
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            idle_fired_ff <= 1'b0;
        end else if (!idle_en) begin
            idle_fired_ff <= 1'b0;
        end else if (rx_access) begin
            idle_fired_ff <= 1'b0;
        end else if (idle_set) begin
            idle_fired_ff <= 1'b1;
        end
    end

    // ==========================================================
    // sticky interrupt status and mask
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rx_req_d_ff <= 1'b0;
            tx_req_d_ff <= 1'b0;
        end else begin
            rx_req_d_ff <= rx_req;
            tx_req_d_ff <= tx_req;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_mask_ff <= 3'h0;
        end else if (WR_IN && (ADDR_IN == `UFM_OFS_IRQ_MASK)) begin
            irq_mask_ff <= WDATA_IN[2:0];
        end
    end

    // one sticky bit per source; set wins over a same-cycle clear
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_stat
            always @(posedge CLOCK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    irq_stat_ff[g] <= 1'b0;
                end else if (irq_event[g]) begin
                    irq_stat_ff[g] <= 1'b1;
                end else if (stat_wr && WDATA_IN[g]) begin
                    irq_stat_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // mode register selected by the pointer
    always @* begin
        case (mode_ptr_ff)
            `UFM_PTR_M0: mode_word = fifo_irq_baud_mode_ff;
            `UFM_PTR_M1: mode_word = char_format_mode_ff;
            default: mode_word = line_mode_reg_ff;
        endcase
    end

    // ==========================================================
    // channel status word
    always @* begin
        status_word = 8'h00;
        status_word[`UFM_ST_RX_HAS_CHAR] = (RX_COUNT_IN != 5'h00) | idle_fired_ff;
        status_word[`UFM_ST_RX_FULL] = (RX_COUNT_IN >= depth);
        status_word[`UFM_ST_TX_SPACE] = (TX_COUNT_IN < depth);
        status_word[`UFM_ST_TX_DRAINED] = (TX_COUNT_IN == 5'h00);
        status_word[`UFM_ST_IDLE_FIRED] = idle_fired_ff;
    end

    // ==========================================================
    // read data
    always @* begin
        nxt_rdata = 8'h00;
        if (RD_IN) begin
            case (ADDR_IN)
                `UFM_OFS_MODE: nxt_rdata = mode_word;
                `UFM_OFS_STATUS: nxt_rdata = status_word;
                `UFM_OFS_IRQ_STAT: nxt_rdata = {5'h00, irq_stat_ff};
                `UFM_OFS_IRQ_MASK: nxt_rdata = {5'h00, irq_mask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // registered outputs
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= nxt_rdata;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RX_IRQ_LEVEL_OUT <= 1'b0;
        end else begin
            RX_IRQ_LEVEL_OUT <= rx_req;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TX_IRQ_LEVEL_OUT <= 1'b0;
        end else begin
            TX_IRQ_LEVEL_OUT <= tx_req;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            QUEUE_DEPTH_SEL_OUT <= 1'b0;
        end else begin
            QUEUE_DEPTH_SEL_OUT <= act_depth_ff;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RATE_GROUP_OUT <= `UFM_RATE_NORMAL;
        end else begin
            RATE_GROUP_OUT <= fifo_irq_baud_mode_ff[`UFM_M0_RATE_HI:`UFM_M0_RATE_LO];
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CHAR_FORMAT_OUT <= `UFM_RST_MODE1;
        end else begin
            CHAR_FORMAT_OUT <= char_format_mode_ff;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            LINE_MODE_OUT <= `UFM_RST_MODE2;
        end else begin
            LINE_MODE_OUT <= line_mode_reg_ff;
        end
    end

    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= irq_any;
        end
    end

endmodule

// >>> sim/ufm_mode_ctl_assertions.sv
// Purpose: port checks for ufm_mode_ctl
// Assumes: sees only the top module ports
// Notes: bound at file foot
`timescale 1ns/1ps
`include "ufm_consts.vh"
module ufm_mode_ctl_assertions (
    input wire CLOCK_IN, // clock
    input wire RST_IN, // reset
    input wire [3:0] ADDR_IN, // address
    input wire [7:0] WDATA_IN, // data
    input wire WR_IN, // write
    input wire RD_IN, // read
    input wire [7:0] RDATA_OUT, // read data
    input wire [4:0] RX_COUNT_IN, // rx fill
    input wire [4:0] TX_COUNT_IN, // tx fill
    input wire TX_ENABLE_IN, // tx on
    input wire RX_IRQ_LEVEL_OUT, // rx req
    input wire TX_IRQ_LEVEL_OUT, // tx req
    input wire [2:0] RATE_GROUP_OUT, // rate
    input wire [7:0] CHAR_FORMAT_OUT, // mode one
    input wire [7:0] LINE_MODE_OUT, // mode two
    input wire IRQ_OUT // irq
);
    reg [7:0] mask_ff;
    // ====
    // copy of the mask register
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_ff <= 8'h00;
        end else if (WR_IN && ADDR_IN == `UFM_OFS_IRQ_MASK) begin
            mask_ff <= WDATA_IN;
        end
    end
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (RST_IN);
    a_read_slot: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside read slot");
    a_tx_needs_en: assert property (!TX_ENABLE_IN |=> !TX_IRQ_LEVEL_OUT)
        else $error("tx request while disabled");
    a_tx_empty_req: assert property (
        (TX_ENABLE_IN && TX_COUNT_IN == 5'h00)[*2] |=> TX_IRQ_LEVEL_OUT)
        else $error("no tx request on empty fifo");
    a_tx_full_quiet: assert property (TX_COUNT_IN == 5'h10 |=> !TX_IRQ_LEVEL_OUT)
        else $error("tx request on full fifo");
    a_rx_full_req: assert property ((RX_COUNT_IN == 5'h10)[*3] |=> RX_IRQ_LEVEL_OUT)
        else $error("no rx request on full fifo");
    a_rx_empty_quiet: assert property ((RX_COUNT_IN == 5'h00)[*3] |=> !RX_IRQ_LEVEL_OUT)
        else $error("rx request on empty fifo");
    a_irq_masked: assert property ((mask_ff == 8'h00)[*2] |=> !IRQ_OUT)
        else $error("irq out with all sources masked");
    a_modes_steady: assert property (
        (!WR_IN)[*3] |=> $stable({RATE_GROUP_OUT, CHAR_FORMAT_OUT, LINE_MODE_OUT}))
        else $error("mode outputs moved without a write");
    c_rx_rise: cover property ($rose(RX_IRQ_LEVEL_OUT));
    c_tx_fall: cover property ($fell(TX_IRQ_LEVEL_OUT));
    c_irq_rise: cover property ($rose(IRQ_OUT));
endmodule
bind ufm_mode_ctl ufm_mode_ctl_assertions u_chk (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .RX_COUNT_IN(RX_COUNT_IN), .TX_COUNT_IN(TX_COUNT_IN),
    .TX_ENABLE_IN(TX_ENABLE_IN), .RX_IRQ_LEVEL_OUT(RX_IRQ_LEVEL_OUT),
    .TX_IRQ_LEVEL_OUT(TX_IRQ_LEVEL_OUT), .RATE_GROUP_OUT(RATE_GROUP_OUT),
    .CHAR_FORMAT_OUT(CHAR_FORMAT_OUT), .LINE_MODE_OUT(LINE_MODE_OUT), .IRQ_OUT(IRQ_OUT));

// >>> sim/ufm_host_model.sv
// Purpose: host processor on the register port
// Assumes: strobes change by nonblocking assignment after a rising edge
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ps
`include "ufm_consts.vh"
module ufm_host_model (
    input wire clk_in, // bus clock
    input wire [7:0] rdata_in, // read data
    output reg [3:0] addr_out = 4'h0, // address
    output reg [7:0] wdata_out = 8'h00, // write data
    output reg wr_out = 1'b0, // write strobe
    output reg rd_out = 1'b0 // read strobe
);
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            addr_out <= a;
            wdata_out <= d;
            wr_out <= 1'b1;
            @(posedge clk_in);
            wr_out <= 1'b0;
            wdata_out <= ~d;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clk_in);
            addr_out <= a;
            rd_out <= 1'b1;
            @(posedge clk_in);
            rd_out <= 1'b0;
            @(negedge clk_in);
            d = rdata_in;
        end
    endtask
    // pointer to mode zero first, then mode zero and mode one in turn
    task set_modes(input [7:0] m0, input [7:0] m1);
        begin
            wr(`UFM_OFS_CMD, {`UFM_CMD_PTR_M0, 4'h0});
            wr(`UFM_OFS_MODE, m0);
            wr(`UFM_OFS_MODE, m1);
        end
    endtask
endmodule

// >>> sim/ufm_mode_ctl_tb_top.sv
// Purpose: self-checking bench for ufm_mode_ctl
// Assumes: host model drives the register port, fifo side driven here
// Notes: expected levels come from the threshold tables
`timescale 1ns/1ps
`include "ufm_consts.vh"
module ufm_mode_ctl_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [4:0] rxc = 5'h00;
    reg [4:0] txc = 5'h00;
    reg [3:0] acc = 4'h0;
    reg tick = 1'b0;
    reg txen = 1'b0;
    reg [7:0] d;
    wire [3:0] addr;
    wire [7:0] wdata, rdata, fmt, line;
    wire wr, rd, rxirq, txirq, dsel, irq;
    wire [2:0] rate;
    integer err_count = 0;
    integer checks_done = 0;
    integer i, j, dep, rc, tc;
    int rxl[8] = '{1, 3, 6, 8, 1, 8, 12, 16};
    int txl[8] = '{8, 4, 6, 1, 16, 8, 12, 1};
    logic [2:0] rt[3] = '{3'h0, 3'h1, 3'h4};
    ufm_mode_ctl u_dut (.CLOCK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_COUNT_IN(rxc), .TX_COUNT_IN(txc),
        .RX_FIFO_RD_IN(acc[0]), .RX_FIFO_WR_IN(acc[1]), .TX_FIFO_RD_IN(acc[2]),
        .TX_FIFO_WR_IN(acc[3]), .RX_BIT_TICK_IN(tick), .TX_ENABLE_IN(txen),
        .RX_IRQ_LEVEL_OUT(rxirq), .TX_IRQ_LEVEL_OUT(txirq), .QUEUE_DEPTH_SEL_OUT(dsel),
        .RATE_GROUP_OUT(rate), .CHAR_FORMAT_OUT(fmt), .LINE_MODE_OUT(line), .IRQ_OUT(irq));
    ufm_host_model u_host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    initial forever #50 clk = ~clk;
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            if (err_count == 0 && checks_done > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task w(input [3:0] a, input [7:0] v);
        begin
            u_host.wr(a, v);
            repeat (2) @(negedge clk);
        end
    endtask
    // new fill counts with one fifo access pulse, then settle
    task step(input [4:0] r, input [4:0] t, input integer k);
        begin
            @(posedge clk);
            rxc <= r;
            txc <= t;
            acc <= 4'h1 << k;
            @(posedge clk);
            acc <= 4'h0;
            repeat (3) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n) begin
                @(posedge clk);
                tick <= 1'b1;
                @(posedge clk);
                tick <= 1'b0;
            end
            repeat (3) @(posedge clk);
            @(negedge clk);
        end
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        err_count = err_count + 1;
        results;
    end
    initial begin
        void'($urandom(87));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        u_host.rd(`UFM_OFS_MODE, d);
        chk("mode1", 8'h00, d);
        w(`UFM_OFS_MODE, 8'h5a);
        chk("line", 8'h5a, line);
        w(`UFM_OFS_CMD, 8'h10);
        w(`UFM_OFS_MODE, 8'ha5);
        chk("fmt", 8'ha5, fmt);
        u_host.rd(`UFM_OFS_MODE, d);
        chk("mode2", 8'h5a, d);
        w(`UFM_OFS_CMD, 8'hb0);
        u_host.rd(`UFM_OFS_MODE, d);
        chk("mode0", 8'h00, d);
        w(4'hf, 8'hff);
        u_host.rd(4'hf, d);
        chk("unmap", 8'h00, d);
        step(0, 0, 0);
        chk("txoff", 8'h00, txirq);
        @(posedge clk) txen <= 1'b1;
        step(0, 0, 2);
        chk("txon", 8'h01, txirq);
        for (i = 0; i < 8; i = i + 1) begin
            step(0, 0, 1);
            u_host.set_modes({1'b0, i[1], i[1:0], i[2], rt[i % 3]}, {1'b0, i[0], 6'h00});
            dep = i[2] ? 16 : 8;
            for (j = 0; j < 4; j = j + 1) begin
                rc = j ? $urandom % (dep + 1) : dep;
                tc = j ? $urandom % (dep + 1) : dep;
                step(rc[4:0], tc[4:0], j);
                chk("rxirq", {7'h00, rc >= rxl[i]}, rxirq);
                chk("txirq", {7'h00, dep - tc >= txl[i]}, txirq);
            end
            chk("depth", {7'h00, i[2]}, dsel);
            chk("rate", {5'h00, rt[i % 3]}, rate);
        end
        step(0, 0, 1);
        u_host.set_modes(8'h00, 8'h00);
        step(3, 0, 1);
        u_host.set_modes(8'h40, 8'h40);
        repeat (3) @(negedge clk);
        chk("hold", 8'h01, rxirq);
        step(3, 0, 0);
        chk("apply", 8'h00, rxirq);
        step(0, 0, 1);
        u_host.set_modes(8'hc8, 8'h40);
        w(`UFM_OFS_IRQ_MASK, 8'hff);
        step(1, 0, 1);
        w(`UFM_OFS_IRQ_STAT, 8'hff);
        ticks(40);
        step(1, 0, 0);
        ticks(63);
        chk("early", 8'h00, rxirq);
        ticks(1);
        chk("fired", 8'h01, rxirq);
        u_host.rd(`UFM_OFS_STATUS, d);
        chk("status", 8'h1d, d);
        u_host.rd(`UFM_OFS_IRQ_STAT, d);
        chk("irqstat", 8'h06, d & 8'h06);
        chk("irq", 8'h01, irq);
        w(`UFM_OFS_IRQ_STAT, 8'hff);
        w(`UFM_OFS_IRQ_MASK, 8'h00);
        step(1, 0, 1);
        chk("clear", 8'h00, {7'h00, rxirq | irq});
        step(0, 0, 1);
        u_host.set_modes(8'h48, 8'h40);
        step(1, 0, 1);
        ticks(64);
        chk("wdoff", 8'h00, rxirq);
        results;
    end
endmodule
